// ==== mcc_cycle_chk.sv ====
// checker for mcc_cycle_ctrl: apb answer timing and cycle start relations
// assumes it is bound to mcc_cycle_ctrl and sees its ports only
`timescale 1ns/100ps
module mcc_cycle_chk (
  input wire        i_sys_clk,
  input wire        i_sys_rst,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        i_auto_pause_en,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_capture_start,
  input wire        o_cycle_is_fast,
  input wire        o_result_refresh,
  input wire [8:0]  o_period_sample_count,
  input wire [15:0] o_cell_channel_enable,
  input wire        o_balancing_pause,
  input wire        o_cycle_busy
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  wire wr   = i_psel & i_penable & o_pready & i_pwrite;
  wire sync = wr & (i_paddr == 16'h600C);
  // no timer pause applies here, so the start must follow at once
  wire now  = sync & ~o_cycle_busy & ~i_auto_pause_en & ~i_pwdata[15]
              & (|o_cell_channel_enable);
  wire held = sync & ~o_cycle_busy & ~o_balancing_pause & i_pwdata[15] & i_pwdata[1]
              & ~i_pwdata[0];

  chk_pready_slot: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("pready missing in second access cycle");
  chk_sync_zero: assert property (
    o_pready && !i_pwrite && i_paddr == 16'h600C |-> o_prdata == 32'h0000_0000)
    else $error("sync control read not zero");
  chk_count_floor: assert property (o_period_sample_count >= 9'h010)
    else $error("sample count below minimum");
  chk_start_now: assert property (now && i_pwdata[0] |=> o_capture_start && !o_cycle_is_fast)
    else $error("paired start missing or flagged fast");
  chk_hold_delay: assert property (
    held |=> !o_capture_start && o_balancing_pause)
    else $error("hold did not pause before capture");
  chk_start_busy: assert property (sync && o_cycle_busy |=> !o_capture_start)
    else $error("start taken while busy");
  chk_hold_ignored: assert property (
    sync && i_pwdata[1:0] == 2'b00 && !o_cycle_busy |=> !o_capture_start ##1 !$rose(o_balancing_pause))
    else $error("hold without start had an effect");
  chk_policy_once: assert property (
    wr && i_paddr == 16'h6008 && i_pwdata[12] |=> o_result_refresh)
    else $error("policy write gave no refresh");
  chk_start_single: assert property (o_capture_start |=> !o_capture_start)
    else $error("capture start longer than one cycle");
endmodule // mcc_cycle_chk

bind mcc_cycle_ctrl mcc_cycle_chk u_chk (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .i_auto_pause_en, .o_prdata, .o_pready, .o_capture_start,
  .o_cycle_is_fast, .o_result_refresh, .o_period_sample_count, .o_cell_channel_enable,
  .o_balancing_pause, .o_cycle_busy);

// ==== mcc_cycle_ctrl.v ====
// measurement cycle control: periodic policy, period length, cycle start strobes
// assumes an APB3 master on i_sys_clk and a sequencer on the same clock
`timescale 1ns/100ps
`include "mcc_defines.vh"
module mcc_cycle_ctrl #(
  parameter SETTLE_CYCLES = `MCC_SETTLE_CYCLES
) (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [15:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_auto_pause_en,
  input  wire        i_meas_done,
  input  wire        i_cycle_done,
  input  wire        i_aux_done,
  output reg         o_capture_start,
  output reg         o_cycle_is_fast,
  output reg         o_aux_capture,
  output reg  [6:0]  o_aux_channels,
  output reg         o_result_refresh,
  output reg  [8:0]  o_period_sample_count,
  output reg  [15:0] o_cell_channel_enable,
  output reg         o_balancing_pause,
  output reg         o_cycle_busy
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         result_update_policy;
  reg  [8:0]  pending_count;
  reg  [8:0]  period_pos;
  reg         cycle_pause;
  reg         next_cycle_pause;
  reg         aux_hold;
  reg         next_capture_start;
  reg         next_fast;
  reg         timer_start;
  reg  [31:0] read_word;
  reg         addr_hit;
  reg         wr_app;
  reg         wr_per;
  reg         wr_sync;
  reg         wr_en;

  wire        timer_expired;
  wire        timer_busy;
  wire [13:0] word_idx = i_paddr[15:2];
  wire        aligned = (i_paddr[1:0] == 2'b00);
  wire        access = i_psel & i_penable & o_pready;
  wire        wr = access & i_pwrite & addr_hit;
  wire [8:0]  wr_count = i_pwdata[`MCC_COUNT_MSB:0];
  wire [6:0]  aux_sel = i_pwdata[`MCC_AUX_MSB:`MCC_AUX_LSB];
  wire        aux_req = wr_app & (|aux_sel);
  // >= rather than == so a period can never overrun its count
  wire        period_end = i_meas_done & (period_pos >= o_period_sample_count - 9'h001);

  wire        sync_wr = wr_sync & i_pwdata[`MCC_SYNC_BIT];
  wire        sync_ok = sync_wr & (|o_cell_channel_enable) & (state == ST_IDLE);
  wire        fast_ok = wr_sync & i_pwdata[`MCC_FAST_BIT] & ~i_pwdata[`MCC_SYNC_BIT]
                        & (state == ST_IDLE);
  wire        start_ok = sync_ok | fast_ok;
  wire        hold_req = start_ok & i_pwdata[`MCC_HOLD_BIT];
  // already paused check
  // an aux pause already running skips the hold's settle wait; the auto pause still waits
  wire        already_paused = aux_hold | cycle_pause;

  // one settle timer serves both the hold request and the auto pause
  mcc_settle_timer #(
    .CYCLES    (SETTLE_CYCLES)
  ) u_settle (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (timer_start),
    .o_expired (timer_expired),
    .o_busy    (timer_busy)
  );

  // write strobes, one per mapped word except status
  always @* begin
    wr_app  = 1'b0;
    wr_per  = 1'b0;
    wr_sync = 1'b0;
    wr_en   = 1'b0;
    if (!wr) begin
      wr_app = 1'b0;
    end else if (word_idx == `MCC_IDX_APP_CTRL) begin
      wr_app = 1'b1;
    end else if (word_idx == `MCC_IDX_PER_CTRL) begin
      wr_per = 1'b1;
    end else if (word_idx == `MCC_IDX_SYNC_CTRL) begin
      wr_sync = 1'b1;
    end else if (word_idx == `MCC_IDX_CH_ENABLE) begin
      wr_en = 1'b1;
    end
  end

  // status and the write-only words are mapped too
  always @* begin
    addr_hit = 1'b1;
    if (!aligned) begin
      addr_hit = 1'b0;
    end else if (word_idx == `MCC_IDX_APP_CTRL) begin
      addr_hit = 1'b1;
    end else if (word_idx == `MCC_IDX_PER_CTRL) begin
      addr_hit = 1'b1;
    end else if (word_idx == `MCC_IDX_SYNC_CTRL) begin
      addr_hit = 1'b1;
    end else if (word_idx == `MCC_IDX_CH_ENABLE) begin
      addr_hit = 1'b1;
    end else if (word_idx == `MCC_IDX_STATUS) begin
      addr_hit = 1'b1;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always @* begin
    read_word = 32'h0000_0000;
    if (!aligned) begin
      read_word = 32'h0000_0000;
    end else if (word_idx == `MCC_IDX_PER_CTRL) begin
      read_word = {19'h0_0000, result_update_policy, 3'b000, pending_count};
    end else if (word_idx == `MCC_IDX_CH_ENABLE) begin
      read_word = {16'h0000, o_cell_channel_enable};
    end else if (word_idx == `MCC_IDX_STATUS) begin
      // bit 5 shows the settle timer so software can poll the wait
      read_word = {26'h000_0000, timer_busy, aux_hold, o_cycle_is_fast, cycle_pause,
                   (state == ST_WAIT), (state != ST_IDLE)};
    end else begin
      read_word = 32'h0000_0000;
    end
  end

  // one wait state: pready and read data both come from flops
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      // error only for unmapped or misaligned words
      o_pslverr <= i_psel & i_penable & ~o_pready & ~addr_hit;
      if (i_psel & i_penable & ~o_pready & ~i_pwrite & addr_hit) begin
        o_prdata <= read_word;
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      result_update_policy <= 1'b0;
      pending_count        <= `MCC_COUNT_RESET;
      o_cell_channel_enable <= `MCC_CH_ENABLE_RESET;
    end else begin
      // readback shows the pending count, not the active one
      if (wr_per) begin
        result_update_policy <= i_pwdata[`MCC_POLICY_BIT];
        if (wr_count < `MCC_COUNT_MIN) begin
          pending_count <= `MCC_COUNT_MIN;
        end else begin
          pending_count <= wr_count;
        end
      end
      if (wr_en) begin
        o_cell_channel_enable <= i_pwdata[15:0];
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      period_pos            <= 9'h000;
      o_period_sample_count <= `MCC_COUNT_RESET;
      o_result_refresh      <= 1'b0;
    end else begin
      o_result_refresh <= 1'b0;
      if (period_end) begin
        period_pos <= 9'h000;
        o_period_sample_count <= pending_count;
      end else if (i_meas_done) begin
        period_pos <= period_pos + 9'h001;
      end
      if (wr_per & i_pwdata[`MCC_POLICY_BIT]) begin
        o_result_refresh <= 1'b1;
      end else if (period_end & ~result_update_policy) begin
        o_result_refresh <= 1'b1;
      end
    end
  end

  always @* begin
    next_state         = state;
    next_cycle_pause   = cycle_pause;
    next_capture_start = 1'b0;
    next_fast          = o_cycle_is_fast;
    timer_start        = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_fast = fast_ok;
          if ((hold_req & ~already_paused) | i_auto_pause_en) begin
            timer_start      = 1'b1;
            next_cycle_pause = 1'b1;
            next_state       = ST_WAIT;
          end else begin
            next_cycle_pause   = hold_req;
            next_capture_start = 1'b1;
            next_state         = ST_RUN;
          end
        end
      end
      ST_WAIT: begin
        // starts written now are dropped: any running cycle blocks them
        // capture after timer
        if (timer_expired) begin
          next_capture_start = 1'b1;
          next_state         = ST_RUN;
        end
      end
      ST_RUN: begin
        // an aux hold keeps the pause after the cycle ends
        if (i_cycle_done) begin
          next_cycle_pause = 1'b0;
          next_state       = ST_IDLE;
        end
      end
      default: begin
        next_cycle_pause = 1'b0;
        next_state       = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state           <= ST_IDLE;
      cycle_pause     <= 1'b0;
      o_capture_start <= 1'b0;
      o_cycle_is_fast <= 1'b0;
      o_cycle_busy    <= 1'b0;
    end else begin
      state           <= next_state;
      cycle_pause     <= next_cycle_pause;
      o_capture_start <= next_capture_start;
      o_cycle_is_fast <= next_fast;
      // busy from the next state so it rises with the write edge
      o_cycle_busy    <= (next_state != ST_IDLE);
    end
  end

  // aux capture with hold; a new hold request in the done cycle wins
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      aux_hold          <= 1'b0;
      o_aux_capture     <= 1'b0;
      o_aux_channels    <= 7'h00;
      o_balancing_pause <= 1'b0;
    end else begin
      o_aux_capture  <= aux_req;
      o_aux_channels <= wr_app ? aux_sel : 7'h00;
      if (aux_req & i_pwdata[`MCC_AUX_HOLD_BIT]) begin
        aux_hold <= 1'b1;
      end else if (i_aux_done) begin
        aux_hold <= 1'b0;
      end
      // pause output
      // taken from the next value so the pause lands with the state change
      o_balancing_pause <= next_cycle_pause | aux_hold;
    end
  end

endmodule // mcc_cycle_ctrl

// ==== mcc_defines.vh ====
// register map, field positions, reset values and timing for the measurement cycle control
// assumes a 50 MHz system clock and word-aligned APB access (byte address = 4 * index)
`ifndef MCC_DEFINES_VH
`define MCC_DEFINES_VH

// register indices; byte address is four times the index
`define MCC_IDX_APP_CTRL      14'h1801
`define MCC_IDX_PER_CTRL      14'h1802
`define MCC_IDX_SYNC_CTRL     14'h1803
`define MCC_IDX_CH_ENABLE     14'h1808
`define MCC_IDX_STATUS        14'h1810

// periodic measurement control fields
`define MCC_POLICY_BIT        12
`define MCC_COUNT_MSB         8
`define MCC_COUNT_RESET       9'h010
`define MCC_COUNT_MIN         9'h010

// synchronous cycle control fields
`define MCC_HOLD_BIT          15
`define MCC_FAST_BIT          1
`define MCC_SYNC_BIT          0

// application control fields used here
`define MCC_AUX_MSB           8
`define MCC_AUX_LSB           2
`define MCC_AUX_HOLD_BIT      15

`define MCC_CH_ENABLE_RESET   16'h0000

// balancing auto-pause settle time
`define MCC_CLK_MHZ           50
`define MCC_SETTLE_TIME_US    100
`define MCC_SETTLE_CYCLES     (`MCC_SETTLE_TIME_US * `MCC_CLK_MHZ)

`endif

// ==== mcc_settle_timer.v ====
// settle timer for the balancing auto pause
// assumes a one-cycle start pulse from logic on the same clock
`timescale 1ns/100ps
module mcc_settle_timer #(
  parameter CYCLES = 5000
) (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  wire        i_start,
  output reg         o_expired,
  output reg         o_busy
);

  localparam [31:0] LAST_WIDE = CYCLES - 1;
  localparam [15:0] LAST      = LAST_WIDE[15:0];

  reg [15:0] count;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count     <= 16'h0000;
      o_busy    <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_start) begin
        count  <= 16'h0000;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count == LAST) begin
          o_busy    <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end

endmodule // mcc_settle_timer

// ==== tb_top.sv ====
// testbench for mcc_cycle_ctrl: register access, period refresh and cycle starts
// assumes the design files and mcc_defines.vh are compiled alongside
`timescale 1ns/100ps
`include "mcc_defines.vh"
module tb_top;
  localparam int ST = 8;
  localparam logic [13:0] APP = `MCC_IDX_APP_CTRL;
  localparam logic [13:0] PER = `MCC_IDX_PER_CTRL;
  localparam logic [13:0] SYN = `MCC_IDX_SYNC_CTRL;
  localparam logic [13:0] ENA = `MCC_IDX_CH_ENABLE;
  localparam logic [13:0] STA = `MCC_IDX_STATUS;
  logic        i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_auto_pause_en = 1'b0, i_meas_done = 1'b0;
  logic        i_cycle_done = 1'b0, i_aux_done = 1'b0, perr;
  logic [15:0] i_paddr = 16'h0000;
  logic [31:0] i_pwdata = 32'h0000_0000, rd, o_prdata;
  logic        o_pready, o_pslverr, o_capture_start, o_cycle_is_fast, o_aux_capture;
  logic        o_result_refresh, o_balancing_pause, o_cycle_busy;
  logic [6:0]  o_aux_channels;
  logic [8:0]  o_period_sample_count;
  logic [15:0] o_cell_channel_enable;
  int          n_fail = 0, cmp_count = 0, cyc = 0, n;

  always #10 i_sys_clk = ~i_sys_clk;

  mcc_cycle_ctrl #(.SETTLE_CYCLES(ST)) dut (.i_sys_clk, .i_sys_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_auto_pause_en,
    .i_meas_done, .i_cycle_done, .i_aux_done, .o_capture_start, .o_cycle_is_fast,
    .o_aux_capture, .o_aux_channels, .o_result_refresh, .o_period_sample_count,
    .o_cell_channel_enable, .o_balancing_pause, .o_cycle_busy);

  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high at an edge
  task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {idx, 2'b00};
    i_pwdata <= d;
    @(posedge i_sys_clk) i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) @(posedge i_sys_clk);
    rd = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task wr_rd(input logic [13:0] idx, input logic [31:0] d, input logic [31:0] exp);
    apb(1'b1, idx, d);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task no_start;
    repeat (4) begin
      @(posedge i_sys_clk);
      chk(o_capture_start, 1'b0);
    end
  endtask

  task end_cycle;
    @(posedge i_sys_clk) i_cycle_done <= 1'b1;
    @(posedge i_sys_clk) i_cycle_done <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    chk(o_cycle_busy, 1'b0);
    chk(o_balancing_pause, 1'b0);
  endtask

  task meas(input logic [31:0] d);
    apb(1'b1, SYN, d);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_capture_start !== 1'b1 && n < 40);
    chk(n, ST + 2);
  endtask

  task pulses(input int k);
    repeat (k) begin
      @(posedge i_sys_clk) i_meas_done <= 1'b1;
      @(posedge i_sys_clk) i_meas_done <= 1'b0;
    end
    @(posedge i_sys_clk);
  endtask

  task s_period;
    chk(o_period_sample_count, 9'h010);
    for (int i = 0; i < 16; i++) begin
      @(posedge i_sys_clk) i_meas_done <= 1'b1;
      @(posedge i_sys_clk) i_meas_done <= 1'b0;
      @(posedge i_sys_clk);
      chk(o_result_refresh, i == 15);
    end
    apb(1'b1, PER, 32'h0000_1010);
    @(posedge i_sys_clk);
    chk(o_result_refresh, 1'b1);
    pulses(16);
    chk(o_result_refresh, 1'b0);
  endtask

  task s_regs;
    apb(1'b0, ENA, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wr_rd(PER, 32'hFFFF_EFFF, 32'h0000_01FF);
    wr_rd(PER, 32'h0000_000F, 32'h0000_0010);
    wr_rd(PER, 32'h0000_0011, 32'h0000_0011);
    chk(o_period_sample_count, 9'h010);
    pulses(16);
    chk(o_period_sample_count, 9'h011);
    chk(o_result_refresh, 1'b1);
    apb(1'b0, 14'h1840, 32'h0000_0000);
    chk(perr, 1'b1);
  endtask

  task s_sync;
    apb(1'b1, SYN, 32'h0000_0001);
    no_start;
    wr_rd(ENA, 32'h0000_0001, 32'h0000_0001);
    chk(o_cell_channel_enable, 16'h0001);
    apb(1'b1, SYN, 32'h0000_0003);
    @(posedge i_sys_clk);
    chk(o_capture_start, 1'b1);
    chk(o_cycle_is_fast, 1'b0);
    apb(1'b1, SYN, 32'h0000_0001);
    no_start;
    apb(1'b0, SYN, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    end_cycle;
  endtask

  task s_hold;
    meas(32'h0000_8002);
    chk(o_cycle_is_fast, 1'b1);
    chk(o_balancing_pause, 1'b1);
    end_cycle;
    i_auto_pause_en <= 1'b1;
    meas(32'h0000_0001);
    end_cycle;
    meas(32'h0000_0002);
    chk(o_cycle_is_fast, 1'b1);
    i_auto_pause_en <= 1'b0;
    end_cycle;
    apb(1'b1, SYN, 32'h0000_8000);
    no_start;
    chk(o_balancing_pause, 1'b0);
    apb(1'b1, APP, 32'h0000_8004);
    @(posedge i_sys_clk);
    chk(o_aux_capture, 1'b1);
    chk(o_aux_channels, 7'h01);
    repeat (2) @(posedge i_sys_clk);
    chk(o_balancing_pause, 1'b1);
    apb(1'b1, SYN, 32'h0000_8001);
    @(posedge i_sys_clk);
    chk(o_capture_start, 1'b1);
    apb(1'b0, STA, 32'h0000_0000);
    chk(rd, 32'h0000_0015);
    @(posedge i_sys_clk) i_aux_done <= 1'b1;
    @(posedge i_sys_clk) i_aux_done <= 1'b0;
    chk(o_balancing_pause, 1'b1);
    end_cycle;
  endtask

  task s_reset;
    apb(1'b1, PER, 32'h0000_1020);
    @(posedge i_sys_clk) i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_balancing_pause, 1'b0);
    chk(o_cell_channel_enable, 16'h0000);
    apb(1'b0, PER, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
  endtask

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    s_period;
    s_regs;
    s_sync;
    s_hold;
    s_reset;
    stop_test;
  end
endmodule // tb_top
